/* logic/fccu_pkg.sv */
// Shared constants, field layouts and decode helpers of the field clear / compare unit
package fccu_pkg;

  // Instruction word field positions
  localparam int unsigned DST_LSB      = 23;
  localparam int unsigned SECOND_OPERAND_LSB     = 18;
  localparam int unsigned FIRST_OPERAND_LSB     = 13;
  localparam int unsigned CSTB_LSB     = 8;
  localparam int unsigned OPF_LSB      = 5;
  localparam int unsigned CLR_PAT_LSB  = 2;
  localparam int unsigned FIELD_W      = 5;
  localparam int unsigned OPF_W        = 7;
  localparam int unsigned CLR_PAT_W    = 6;

  // Fixed pattern of the constant-form field clear
  localparam logic [CLR_PAT_W-1:0] CLR_PATTERN = 6'h32;

  // Fixed tail of a logic-unit compare word
  localparam int unsigned CMP_TAIL_LSB = 2;
  localparam int unsigned CMP_TAIL_W   = 3;
  localparam logic [2:0]  CMP_TAIL     = 3'h6;

  // Register-form bound positions inside the first operand
  localparam int unsigned HI_BOUND_LSB = 0;
  localparam int unsigned LO_BOUND_LSB = 5;

  // Compare opfield groups (upper five bits) and operand forms (low two bits)
  localparam logic [4:0] OPF_EQ_GRP    = 5'h14;
  localparam logic [4:0] OPF_GT_GRP    = 5'h11;
  localparam logic [4:0] OPF_GTU_GRP   = 5'h13;
  localparam logic [1:0] FORM_WORD     = 2'h3;
  localparam logic [1:0] FORM_CST_WORD = 2'h2;
  localparam logic [1:0] FORM_WORD_LNG = 2'h1;
  localparam logic [1:0] FORM_CST_LNG  = 2'h0;

  localparam int unsigned WORD_W = 32;
  localparam int unsigned LONG_W = 40;

  // Branch delay slots
  localparam logic [2:0] DELAY_SLOTS = 3'h5;

  // APB register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] FETCH_OFS  = 8'h08;
  localparam logic [7:0] BRCNT_OFS  = 8'h0C;

  // Control register layout and reset value
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0001;

  // Status register layout
  localparam int unsigned ST_NONMASKABLE_IRQ_ENABLE_BIT_BIT  = 0;
  localparam int unsigned ST_BLOCK_BIT = 1;
  localparam int unsigned ST_SLOT_LSB  = 4;

  typedef enum logic [1:0] {
    FCCU_CMP_EQ,
    FCCU_CMP_GT,
    FCCU_CMP_GTU,
    FCCU_CMP_NONE
  } fccu_cmp_type;

  // Destination register index of an instruction word
  function automatic logic [FIELD_W-1:0] fccu_dst(input logic [31:0] w);
    fccu_dst = w[DST_LSB +: FIELD_W];
  endfunction : fccu_dst

endpackage : fccu_pkg

/* logic/fccu_clear.sv */
// Bit-field clear datapath of one shift unit
module fccu_clear
  import fccu_pkg::*;
(
  input  wire logic [31:0] instr,
  input  wire logic        reg_form,
  input  wire logic [31:0] first_operand,
  input  wire logic [31:0] second_operand,
  output logic             legal,
  output logic [31:0]      result
);

  logic [FIELD_W-1:0] lo_bound;
  logic [FIELD_W-1:0] hi_bound;
  logic [31:0]        keep;

  // Bound selection: register operand or instruction constants
  always_comb
  begin
    if (reg_form)
    begin
      hi_bound = first_operand[HI_BOUND_LSB +: FIELD_W]; // [RULE8]
      lo_bound = first_operand[LO_BOUND_LSB +: FIELD_W]; // [RULE8]
      legal    = 1'b1;
    end
    else
    begin
      hi_bound = instr[CSTB_LSB +: FIELD_W]; // [RULE10]
      lo_bound = instr[FIRST_OPERAND_LSB +: FIELD_W]; // [RULE10]
      legal    = (instr[CLR_PAT_LSB +: CLR_PAT_W] == CLR_PATTERN); // [RULE10]
    end
  end

  // Per-bit keep mask, bit 0 is the LSB
  for (genvar i = 0; i < WORD_W; i++)
  begin : g_mask
    assign keep[i] = !((5'(i) >= lo_bound) && (5'(i) <= hi_bound)); // [RULE7]
  end

  assign result = second_operand & keep; // [RULE7]

endmodule : fccu_clear

/* logic/fccu_compare.sv */
// Equality / signed / unsigned greater-than compare of one logic unit
module fccu_compare
  import fccu_pkg::*;
(
  input  wire logic [31:0] instr,
  input  wire logic [31:0] first_operand,
  input  wire logic [31:0] second_operand,
  input  wire logic [39:0] long_operand,
  output logic             legal,
  output logic [31:0]      result
);

  logic [OPF_W-1:0]  opf;
  logic [1:0]        form;
  fccu_cmp_type      kind;
  logic [LONG_W-1:0] a;
  logic [LONG_W-1:0] b;
  logic [FIELD_W-1:0] cst;
  logic              hit;

  assign opf  = instr[OPF_LSB +: OPF_W];
  assign form = opf[1:0];
  assign cst  = instr[FIRST_OPERAND_LSB +: FIELD_W];

  // Opfield group decode
  always_comb
  begin
    case (opf[6:2])
      OPF_EQ_GRP:  kind = FCCU_CMP_EQ;  // [RULE13]
      OPF_GT_GRP:  kind = FCCU_CMP_GT;  // [RULE15]
      OPF_GTU_GRP: kind = FCCU_CMP_GTU; // [RULE18]
      default:     kind = FCCU_CMP_NONE;
    endcase
  end

  // Operand forming: constant only first, long only second
  always_comb
  begin
    a = (kind == FCCU_CMP_GTU) ? {8'h00, first_operand} : {{8{first_operand[31]}}, first_operand};
    b = (kind == FCCU_CMP_GTU) ? {8'h00, second_operand}
                               : {{8{second_operand[31]}}, second_operand};
    if (form == FORM_CST_WORD || form == FORM_CST_LNG)
    begin
      if (kind == FCCU_CMP_GTU)
        a = {36'h0_0000_0000, cst[3:0]}; // [RULE19]
      else
        a = {{35{cst[4]}}, cst}; // [RULE16]
    end
    if (form == FORM_WORD_LNG || form == FORM_CST_LNG)
      b = long_operand; // [RULE21]
  end

  // Compare at full long width
  always_comb
  begin
    case (kind)
      FCCU_CMP_EQ:  hit = (a == b);                   // [RULE12]
      FCCU_CMP_GT:  hit = ($signed(a) > $signed(b));  // [RULE14]
      FCCU_CMP_GTU: hit = (a > b);                    // [RULE17]
      default:      hit = 1'b0;
    endcase
  end

  assign legal  = (kind != FCCU_CMP_NONE) && (instr[CMP_TAIL_LSB +: CMP_TAIL_W] == CMP_TAIL);
  assign result = {31'h0000_0000, hit}; // [RULE23]

endmodule : fccu_compare

/* logic/fccu_top.sv */
// Field clear, compare and NMI-return branch execute slice with APB status registers
//
// What this block does
// RULE1: Taken return loads pointer, sets NMI enable.
// RULE2: Return branch only on second shift unit.
// RULE3: Never two taken branches per packet.
// RULE4: Displacement plus return branch, one taken.
// RULE5: Block interrupts during all branch delay slots.
// RULE6: Return branch has five delay slots.
// RULE7: Clear bits low bound through high bound.
// RULE8: Register bounds: high 4..0, low 9..5.
// RULE9: Upper 22 bound bits kept zero.
// RULE10: Decode constant-form clear instruction fields.
// RULE11: Clear and compares write in first stage.
// RULE12: Equality compare writes one or zero.
// RULE13: Equality opfield selects operand forms.
// RULE14: Signed greater-than writes one or zero.
// RULE15: Signed greater-than opfield selects forms.
// RULE16: Constant first only, cross path second.
// RULE17: Unsigned greater-than writes one or zero.
// RULE18: Unsigned greater-than opfield selects forms.
// RULE19: Unsigned constant top bit kept zero.
// RULE20: Compares on logic, clear on shift units.
// RULE21: Long operand compared at forty bits.
// RULE22: False predicate performs no update.
// RULE23: Compare result bit zero, rest cleared.
//
// Register access over APB and the address map were decided locally.
module fccu_top
  import fccu_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Shift units: field clear
  input  wire logic [1:0]       s_valid,
  input  wire logic [1:0]       s_pred,
  input  wire logic [1:0]       s_reg_form,
  input  wire logic [1:0][31:0] s_instr,
  input  wire logic [1:0][31:0] s_first_operand,
  input  wire logic [1:0][31:0] s_second_operand,
  output logic      [1:0]       s_wr_en,
  output logic      [1:0][4:0]  s_wr_addr,
  output logic      [1:0][31:0] s_wr_data,
  // Logic units: compares
  input  wire logic [1:0]       l_valid,
  input  wire logic [1:0]       l_pred,
  input  wire logic [1:0][31:0] l_instr,
  input  wire logic [1:0][31:0] l_first_operand,
  input  wire logic [1:0][31:0] l_second_operand,
  input  wire logic [1:0][39:0] l_long_operand,
  output logic      [1:0]       l_wr_en,
  output logic      [1:0][4:0]  l_wr_addr,
  output logic      [1:0][31:0] l_wr_data,
  // NMI return branch on the second shift unit
  input  wire logic             nrp_branch_valid,
  input  wire logic             nrp_branch_pred,
  input  wire logic [31:0]      nmi_return_pointer,
  // Displacement branch of the same packet
  input  wire logic             disp_branch_valid,
  input  wire logic             disp_branch_pred,
  input  wire logic [31:0]      disp_branch_target,
  // Interrupt controller clears the enable on NMI entry
  input  wire logic             nmi_accept,
  output logic      [31:0]      program_fetch_counter,
  output logic                  fetch_load,
  output logic                  nonmaskable_irq_enable_bit,
  output logic                  irq_block,
  output logic                  target_start
);

  // Unit result wires
  logic [1:0]       clr_legal;
  logic [1:0][31:0] clr_result;
  logic [1:0]       cmp_legal;
  logic [1:0][31:0] cmp_result;

  // Writeback state
  logic [1:0]       s_wr_en_q,   s_wr_en_d;
  logic [1:0][4:0]  s_wr_addr_q, s_wr_addr_d;
  logic [1:0][31:0] s_wr_data_q, s_wr_data_d;
  logic [1:0]       l_wr_en_q,   l_wr_en_d;
  logic [1:0][4:0]  l_wr_addr_q, l_wr_addr_d;
  logic [1:0][31:0] l_wr_data_q, l_wr_data_d;

  // Branch state
  logic [31:0] pfc_q,     pfc_d;
  logic        load_q,    load_d;
  logic        nonmaskable_irq_enable_bit_q,    nonmaskable_irq_enable_bit_d;
  logic [2:0]  slot_q,    slot_d;
  logic        taken_q,   taken_d;
  logic        block_q,   block_d;
  logic        start_q,   start_d;
  logic [31:0] brcnt_q,   brcnt_d;

  // Register bus state
  logic [31:0] ctrl_q,    ctrl_d;
  logic [31:0] prdata_q,  prdata_d;
  logic        pready_q,  pready_d;
  logic        pslverr_q, pslverr_d;

  logic        unit_en;
  logic        branch_exec;
  logic        nrp_taken;
  logic        disp_taken;

  assign unit_en = ctrl_q[CTRL_EN_BIT];

  // One clear datapath per shift unit, one compare per logic unit
  for (genvar u = 0; u < 2; u++)
  begin : g_unit
    fccu_clear u_clear (
      .instr          (s_instr[u]),
      .reg_form       (s_reg_form[u]),
      .first_operand  (s_first_operand[u]),
      .second_operand (s_second_operand[u]),
      .legal          (clr_legal[u]),
      .result         (clr_result[u])
    );
    fccu_compare u_cmp (
      .instr          (l_instr[u]),
      .first_operand  (l_first_operand[u]),
      .second_operand (l_second_operand[u]),
      .long_operand   (l_long_operand[u]),
      .legal          (cmp_legal[u]),
      .result         (cmp_result[u])
    );
  end

  // Single-cycle writeback, visible the cycle after execute
  always_comb
  begin
    for (int u = 0; u < 2; u++)
    begin
      s_wr_en_d[u]   = unit_en && s_valid[u] && s_pred[u] && clr_legal[u]; // [RULE20] [RULE22]
      s_wr_addr_d[u] = fccu_dst(s_instr[u]);
      s_wr_data_d[u] = clr_result[u]; // [RULE11]
      l_wr_en_d[u]   = unit_en && l_valid[u] && l_pred[u] && cmp_legal[u]; // [RULE20] [RULE22]
      l_wr_addr_d[u] = fccu_dst(l_instr[u]);
      l_wr_data_d[u] = cmp_result[u]; // [RULE11]
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_wr_en_q   <= '0;
      s_wr_addr_q <= '0;
      s_wr_data_q <= '0;
      l_wr_en_q   <= '0;
      l_wr_addr_q <= '0;
      l_wr_data_q <= '0;
    end
    else if (ce)
    begin
      s_wr_en_q   <= s_wr_en_d;
      s_wr_addr_q <= s_wr_addr_d;
      s_wr_data_q <= s_wr_data_d;
      l_wr_en_q   <= l_wr_en_d;
      l_wr_addr_q <= l_wr_addr_d;
      l_wr_data_q <= l_wr_data_d;
    end
  end

  // Branch execution: fetch redirect, enable bit, delay slots
  always_comb
  begin
    branch_exec = unit_en && (nrp_branch_valid || disp_branch_valid);
    nrp_taken   = unit_en && nrp_branch_valid && nrp_branch_pred; // [RULE2]
    disp_taken  = unit_en && disp_branch_valid && disp_branch_pred;
    pfc_d   = pfc_q;
    load_d  = 1'b0;
    nonmaskable_irq_enable_bit_d  = nonmaskable_irq_enable_bit_q;
    slot_d  = slot_q;
    taken_d = taken_q;
    start_d = 1'b0;
    brcnt_d = brcnt_q;
    if (nmi_accept)
      nonmaskable_irq_enable_bit_d = 1'b0;
    if (slot_q != 3'h0)
    begin
      slot_d = slot_q - 3'h1;
      if (slot_q == 3'h1)
      begin
        start_d = taken_q; // [RULE6]
        taken_d = 1'b0;
      end
    end
    if (branch_exec)
    begin
      slot_d  = DELAY_SLOTS; // [RULE5] [RULE6]
      taken_d = nrp_taken || disp_taken;
      brcnt_d = brcnt_q + 32'h0000_0001;
    end
    // Return branch wins if software breaks the one-taken contract
    if (nrp_taken)
    begin
      pfc_d  = nmi_return_pointer; // [RULE1] [RULE3]
      load_d = 1'b1;
      nonmaskable_irq_enable_bit_d = 1'b1; // [RULE1]
    end
    else if (disp_taken)
    begin
      pfc_d  = disp_branch_target; // [RULE4]
      load_d = 1'b1;
    end
    block_d = (slot_d != 3'h0); // [RULE5]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pfc_q   <= '0;
      load_q  <= 1'b0;
      nonmaskable_irq_enable_bit_q  <= 1'b0;
      slot_q  <= '0;
      taken_q <= 1'b0;
      block_q <= 1'b0;
      start_q <= 1'b0;
      brcnt_q <= '0;
    end
    else if (ce)
    begin
      pfc_q   <= pfc_d;
      load_q  <= load_d;
      nonmaskable_irq_enable_bit_q  <= nonmaskable_irq_enable_bit_d;
      slot_q  <= slot_d;
      taken_q <= taken_d;
      block_q <= block_d;
      start_q <= start_d;
      brcnt_q <= brcnt_d;
    end
  end

  // APB slave: one wait state, error on unmapped offsets
  always_comb
  begin
    ctrl_d    = ctrl_q;
    prdata_d  = prdata_q;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    if (psel && penable && !pready_q)
    begin
      pready_d = 1'b1;
      prdata_d = '0;
      case (paddr)
        CTRL_OFS:   prdata_d = ctrl_q;
        STATUS_OFS:
        begin
          prdata_d[ST_NONMASKABLE_IRQ_ENABLE_BIT_BIT]          = nonmaskable_irq_enable_bit_q;
          prdata_d[ST_BLOCK_BIT]         = block_q;
          prdata_d[ST_SLOT_LSB +: 3]     = slot_q;
        end
        FETCH_OFS:  prdata_d = pfc_q;
        BRCNT_OFS:  prdata_d = brcnt_q;
        default:    pslverr_d = 1'b1;
      endcase
    end
    if (psel && penable && pready_q && pwrite && (paddr == CTRL_OFS))
      ctrl_d = {31'h0000_0000, pwdata[CTRL_EN_BIT]};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q    <= CTRL_RESET;
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else if (ce)
    begin
      ctrl_q    <= ctrl_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Outputs straight from flops
  assign s_wr_en                    = s_wr_en_q;
  assign s_wr_addr                  = s_wr_addr_q;
  assign s_wr_data                  = s_wr_data_q;
  assign l_wr_en                    = l_wr_en_q;
  assign l_wr_addr                  = l_wr_addr_q;
  assign l_wr_data                  = l_wr_data_q;
  assign program_fetch_counter      = pfc_q;
  assign fetch_load                 = load_q;
  assign nonmaskable_irq_enable_bit = nonmaskable_irq_enable_bit_q;
  assign irq_block                  = block_q;
  assign target_start               = start_q;
  assign prdata                     = prdata_q;
  assign pready                     = pready_q;
  assign pslverr                    = pslverr_q;

endmodule : fccu_top

/* tb/fccu_top_sva.sv */
// Assertion checker of the execute slice outputs
module fccu_top_chk
  import fccu_pkg::*;
(
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic [1:0]       s_valid,
  input wire logic [1:0]       s_pred,
  input wire logic [1:0]       s_wr_en,
  input wire logic [1:0][31:0] l_instr,
  input wire logic [1:0]       l_wr_en,
  input wire logic [1:0][4:0]  l_wr_addr,
  input wire logic [1:0][31:0] l_wr_data,
  input wire logic             nrp_branch_valid,
  input wire logic             nrp_branch_pred,
  input wire logic [31:0]      nmi_return_pointer,
  input wire logic             disp_branch_valid,
  input wire logic             disp_branch_pred,
  input wire logic [31:0]      disp_branch_target,
  input wire logic [31:0]      program_fetch_counter,
  input wire logic             fetch_load,
  input wire logic             nonmaskable_irq_enable_bit,
  input wire logic             irq_block,
  input wire logic             target_start
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Taken branch, then five quiet packets
  sequence taken_s;
    (nrp_branch_valid && nrp_branch_pred) || (disp_branch_valid && disp_branch_pred);
  endsequence
  sequence quiet_s;
    !(nrp_branch_valid || disp_branch_valid) [*5];
  endsequence

  AST_NRP_LOAD: assert property (nrp_branch_valid && nrp_branch_pred |=> fetch_load &&
    nonmaskable_irq_enable_bit && program_fetch_counter == $past(nmi_return_pointer))
    else $error("return branch did not load its pointer");
  AST_DISP_LOAD: assert property (disp_branch_valid && disp_branch_pred &&
    !(nrp_branch_valid && nrp_branch_pred) |=> program_fetch_counter == $past(disp_branch_target))
    else $error("displacement branch target lost");
  AST_SLOT_BLOCK: assert property (nrp_branch_valid || disp_branch_valid |=> irq_block [*5])
    else $error("interrupts open in a delay slot");
  AST_TARGET: assert property (taken_s ##1 quiet_s |=> target_start)
    else $error("target did not start in the sixth cycle");
  AST_NO_FETCH: assert property (fetch_load |->
    $past((nrp_branch_valid && nrp_branch_pred) || (disp_branch_valid && disp_branch_pred)))
    else $error("fetch load without a taken branch");
  AST_NONMASKABLE_IRQ_ENABLE_BIT_SET: assert property ($rose(nonmaskable_irq_enable_bit) |->
    $past(nrp_branch_valid && nrp_branch_pred)) else $error("enable set without return");
  AST_WR_PRED: assert property ((s_wr_en & ~$past(s_valid & s_pred)) == 2'h0)
    else $error("field clear wrote without a true predicate");
  AST_CMP_WORD: assert property (l_wr_en[0] |-> l_wr_data[0][31:1] == 31'h0 &&
    l_wr_addr[0] == $past(l_instr[0][27:23])) else $error("compare writeback malformed");
endmodule : fccu_top_chk

bind fccu_top fccu_top_chk u_chk (.pclk, .presetn, .s_valid, .s_pred, .s_wr_en, .l_instr,
  .l_wr_en, .l_wr_addr, .l_wr_data, .nrp_branch_valid, .nrp_branch_pred, .nmi_return_pointer,
  .disp_branch_valid, .disp_branch_pred, .disp_branch_target, .program_fetch_counter,
  .fetch_load, .nonmaskable_irq_enable_bit, .irq_block, .target_start);

/* tb/fccu_rf_model.sv */
// Register file model fed by the writeback ports
module fccu_rf_model
(
  input wire logic             pclk,
  input wire logic [1:0]       s_wr_en,
  input wire logic [1:0][4:0]  s_wr_addr,
  input wire logic [1:0][31:0] s_wr_data,
  input wire logic [1:0]       l_wr_en,
  input wire logic [1:0][4:0]  l_wr_addr,
  input wire logic [1:0][31:0] l_wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rf [32];

  // Writes of all four units at the edge
  always_ff @(posedge pclk)
  begin
    for (int u = 0; u < 2; u++)
    begin
      if (s_wr_en[u])
        rf[s_wr_addr[u]] <= s_wr_data[u];
      if (l_wr_en[u])
        rf[l_wr_addr[u]] <= l_wr_data[u];
    end
  end
endmodule : fccu_rf_model

/* tb/fccu_top_bench.sv */
// Self-checking bench of the field clear / compare execute slice
module fccu_top_bench
  import fccu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic             pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic             nrp_branch_valid, nrp_branch_pred, disp_branch_valid, disp_branch_pred;
  logic             nmi_accept, fetch_load, nonmaskable_irq_enable_bit, irq_block, target_start;
  logic             exp_nonmaskable_irq_enable_bit;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, nmi_return_pointer, disp_branch_target;
  logic [31:0]      program_fetch_counter, exp_pfc;
  logic [1:0]       s_valid, s_pred, s_reg_form, s_wr_en, l_valid, l_pred, l_wr_en;
  logic [1:0][4:0]  s_wr_addr, l_wr_addr;
  logic [1:0][31:0] s_instr, s_first_operand, s_second_operand, s_wr_data;
  logic [1:0][31:0] l_instr, l_first_operand, l_second_operand, l_wr_data;
  logic [1:0][39:0] l_long_operand;
  int               n_mismatch = 0;
  int               n_compared = 0;

  fccu_top      DUT (.*);
  fccu_rf_model RF (.*);

  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic test_done;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_w

  task automatic chk_b(input logic got, input logic exp);
    chk_w({31'h0, got}, {31'h0, exp});
  endtask : chk_b

  // APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int k;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, wd};
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (k == 20)
    begin
      n_mismatch++;
      test_done;
    end
    // Answer taken at the edge that samples pready, then release
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask : apb

  // One packet on both shift and both logic units
  task automatic op_round(input int i, input logic en);
    logic [31:0] a, b, e, ed [4];
    logic [39:0] lg;
    logic [4:0]  c, d, lo, hi, grp, dst [4];
    logic [3:0]  ev;
    logic [1:0]  f;
    logic        r, p, s;
    longint      x, y;
    int          g, dl;
    @(posedge pclk);
    for (int u = 0; u < 4; u++)
    begin
      {a, b, c, d, r} = {$urandom, $urandom, 5'($urandom), 5'($urandom), 1'($urandom)};
      lg = 40'({$urandom, $urandom});
      p = ($urandom % 4) != 0;
      dst[u] = 5'(u * 8) + 5'($urandom % 8);
      ev[u] = p & en;
      if (u < 2)
      begin
        a[31:10] = 22'h0; // Bound operand
        lo = r ? a[9:5] : c;
        hi = r ? a[4:0] : d;
        e = b;
        for (int k = 0; k < 32; k++)
          if (k >= lo && k <= hi)
            e[k] = 1'b0;
        ed[u] = e;
        g = int'(!r && ($urandom % 8) == 0); // Broken constant-form pattern
        ev[u] = ev[u] & (g == 0);
        {s_valid[u], s_pred[u], s_reg_form[u]} <= {1'b1, p, r};
        {s_first_operand[u], s_second_operand[u]} <= {a, b};
        s_instr[u] <= {4'h0, dst[u], 5'h0, c, d, CLR_PATTERN ^ 6'(g), 2'h0};
      end
      else
      begin
        g = (i + u) % 3;
        f = 2'((i + u) / 3);
        s = g != 2;
        grp = g == 0 ? OPF_EQ_GRP : (g == 1 ? OPF_GT_GRP : OPF_GTU_GRP);
        if (!s)
          c[4] = 1'b0; // Constant top bit
        if (f[0])
          x = s ? longint'(signed'(a)) : longint'(a);
        else
          x = s ? longint'(signed'(c)) : longint'(c[3:0]);
        dl = int'($urandom % 4) - 1;
        if (dl < 2)
          {b, lg} = {32'(x + dl), 40'(x + dl)};
        if (f[1])
          y = s ? longint'(signed'(b)) : longint'(b);
        else
          y = s ? longint'(signed'(lg)) : longint'(lg);
        ed[u] = {31'h0, g == 0 ? x == y : x > y};
        {l_valid[u-2], l_pred[u-2]} <= {1'b1, p};
        {l_first_operand[u-2], l_second_operand[u-2], l_long_operand[u-2]} <= {a, b, lg};
        l_instr[u-2] <= {4'h0, dst[u], 5'h0, c, 1'b0, grp, f, 5'h18};
      end
    end
    @(posedge pclk);
    {s_valid, l_valid} <= 4'h0;
    @(negedge pclk);
    chk_w({28'h0, l_wr_en, s_wr_en}, {28'h0, ev}); // Enables
    @(negedge pclk);
    for (int u = 0; u < 4; u++)
      if (ev[u])
        chk_w(RF.rf[dst[u]], ed[u]);
  endtask : op_round

  // One branch packet and its six following cycles
  task automatic branch(input logic nv, input logic np, input logic dv, input logic dp);
    logic [31:0] pn, pd;
    logic        tk;
    {pn, pd} = {$urandom, $urandom};
    tk = (nv & np) | (dv & dp);
    if (tk)
      exp_pfc = (nv & np) ? pn : pd;
    if (nv & np)
      exp_nonmaskable_irq_enable_bit = 1'b1;
    @(posedge pclk);
    {nrp_branch_valid, nrp_branch_pred, disp_branch_valid, disp_branch_pred} <= {nv, np, dv, dp};
    {nmi_return_pointer, disp_branch_target} <= {pn, pd};
    @(posedge pclk);
    {nrp_branch_valid, disp_branch_valid} <= 2'b00;
    for (int k = 1; k <= 6; k++)
    begin
      @(negedge pclk);
      chk_b(irq_block, k < 6); // Slot blocking
      chk_b(target_start, tk && k == 6); // Target start
      chk_b(fetch_load, tk && k == 1); // Load pulse
    end
    chk_w(program_fetch_counter, exp_pfc);
    chk_b(nonmaskable_irq_enable_bit, exp_nonmaskable_irq_enable_bit);
  endtask : branch

  // Main sequence
  initial
  begin
    logic [31:0] rd;
    logic        er;
    {presetn, psel, penable, pwrite, paddr, pwdata, nmi_accept} = '0;
    {s_valid, s_pred, s_reg_form, s_instr, s_first_operand, s_second_operand} = '0;
    {l_valid, l_pred, l_instr, l_first_operand, l_second_operand, l_long_operand} = '0;
    {nrp_branch_valid, nrp_branch_pred, disp_branch_valid, disp_branch_pred} = '0;
    {nmi_return_pointer, disp_branch_target, exp_pfc, exp_nonmaskable_irq_enable_bit} = '0;
    ce = 1'b1;
    void'($urandom(73));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CTRL_OFS, 32'h0, rd, er);
    chk_w(rd, CTRL_RESET);
    apb(1'b0, 8'h10, 32'h0, rd, er);
    chk_b(er, 1'b1);
    chk_w(rd, 32'h0);
    apb(1'b1, CTRL_OFS, 32'h0, rd, er);
    op_round(0, 1'b0); // Disabled slice
    apb(1'b1, CTRL_OFS, 32'h1, rd, er);
    $display("register test done");
    for (int i = 0; i < 120; i++)
      op_round(i, 1'b1);
    $display("operation test done");
    branch(1'b1, 1'b1, 1'b0, 1'b0); // One taken branch
    branch(1'b1, 1'b0, 1'b1, 1'b1);
    branch(1'b1, 1'b1, 1'b1, 1'b0);
    branch(1'b0, 1'b0, 1'b1, 1'b0);
    @(posedge pclk);
    nmi_accept <= 1'b1;
    @(posedge pclk);
    nmi_accept <= 1'b0;
    exp_nonmaskable_irq_enable_bit = 1'b0;
    branch(1'b1, 1'b0, 1'b0, 1'b0);
    apb(1'b0, STATUS_OFS, 32'h0, rd, er);
    chk_w(rd, 32'h0);
    branch(1'b1, 1'b1, 1'b0, 1'b0);
    apb(1'b0, FETCH_OFS, 32'h0, rd, er);
    chk_w(rd, exp_pfc);
    $display("branch test done");
    test_done;
  end
endmodule : fccu_top_bench
